// >>> include/sadc_pkg.sv
/*
  sadc_pkg: constants, types and control-byte layout for the serial
  converter control block.
  assumes: used by rtl/sadc_ctrl.sv, not by rtl/sadc_fifo.sv, no import.
*/
// Function
// - shift data in on rising serial clock
// - skip leading zeros, first one starts byte
// - bit 3 chooses unipolar or bipolar coding
// - bit 2 chooses single-ended or differential input
// - single-ended select code maps to channel
// - differential codes choose pair and polarity
// - start plus both power bits selects external clock
// - strobe high one period before result msb
// - strobe and data out change on falling edge
// - back-to-back conversions take fifteen clocks
// - result framed by one zero, three zeros
// - unipolar plain binary, bipolar two's complement
// - result shifted out msb first
// - data out released while chip select high
// - track after fifth bit, hold after eighth
// - conversion starts on falling edge after eighth bit
package sadc_pkg;

  // control-byte field positions
  localparam int unsigned SADC_BIT_START = 7;
  localparam int unsigned SADC_BIT_SEL_HI = 6;
  localparam int unsigned SADC_BIT_SEL_MID = 5;
  localparam int unsigned SADC_BIT_SEL_LO = 4;
  localparam int unsigned SADC_BIT_CODING = 3;
  localparam int unsigned SADC_BIT_CONFIG = 2;
  localparam int unsigned SADC_BIT_PWR_HI = 1;
  localparam int unsigned SADC_BIT_PWR_LO = 0;

  // widths and counts
  localparam int unsigned SADC_RES_W = 12;
  localparam int unsigned SADC_CTRL_W = 8;
  localparam logic [3:0] SADC_TRACK_BIT = 4'h5;
  localparam logic [3:0] SADC_LAST_BIT = 4'h8;
  localparam logic [3:0] SADC_RES_LAST = 4'hb;
  // result bits out (msb down to bit 5) before a new start bit counts
  localparam logic [3:0] SADC_RESTART_BIT = 4'h7;
  localparam int unsigned SADC_FIFO_DEPTH = 16;

  // serial clock limits of the master, for reference
  localparam int unsigned SADC_SCLK_MIN_KHZ = 100;
  localparam int unsigned SADC_SCLK_MAX_KHZ = 2000;
  localparam int unsigned SADC_SEQ_MAX_US = 120;
  localparam int unsigned SADC_MCLK_MHZ = 100;
  localparam int unsigned SADC_SEQ_MAX_CYC = SADC_SEQ_MAX_US * SADC_MCLK_MHZ;

  // power-mode decode
  typedef enum logic [1:0] {
    SADC_PM_FULL_PD = 2'h0,
    SADC_PM_FAST_PD = 2'h1,
    SADC_PM_INT_CLK = 2'h2,
    SADC_PM_EXT_CLK = 2'h3
  } sadc_pmode_t;

  // power code to mode table, index is {hi, lo}
  localparam logic [7:0] SADC_PM_TABLE = 8'he4;
  localparam logic [1:0] SADC_PM_EXT_CODE = 2'h3;

  // reset value of decoded configuration
  localparam logic [1:0] SADC_PM_RESET = 2'h2;

  // decoded control byte
  typedef struct packed {
    logic [2:0] chan_pos;   // positive channel
    logic [2:0] chan_neg;   // negative channel (diff only)
    logic neg_is_gnd;       // single-ended: negative is ground
    logic unipolar;         // 1 plain binary, 0 two's complement
    logic [1:0] pmode;      // decoded power/clock mode
  } sadc_cfg_t;

  // fifo word: configuration plus result
  typedef struct packed {
    sadc_cfg_t cfg;
    logic [11:0] result;
  } sadc_word_t;

  localparam int unsigned SADC_WORD_W = $bits(sadc_word_t);

endpackage : sadc_pkg

// >>> rtl/sadc_fifo.sv
/*
  sadc_fifo: synchronous fifo, parameter width and depth.
  assumes: single clock mclk, synchronous active-high reset.
*/
`timescale 1ns/100ps
module sadc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  // storage and pointers
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // write storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : sadc_fifo

// >>> rtl/sadc_ctrl.sv
/*
  sadc_ctrl: serial control and result port of an eight-channel 12-bit
  converter, run from external serial clock in external clock mode.
  assumes: mclk much faster than sclk; pins are asynchronous and are
  synchronised here; the analog core returns a comparator decision per
  falling edge on cmp_bit; the user side drains a fifo of conversions.
*/
`timescale 1ns/100ps
module sadc_ctrl #(
  parameter int unsigned DEPTH = sadc_pkg::SADC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe,
  // analog core
  input wire logic cmp_bit,
  output logic track_q,
  output logic convert_q,
  output sadc_pkg::sadc_cfg_t cfg_q,
  // conversion record stream
  output logic rec_valid,
  input wire logic rec_ready,
  output sadc_pkg::sadc_word_t rec_data,
  output logic rec_dropped_q
);

  // pin synchronisers, first stage read only by second
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic sclk_prev_q;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic rise;
  logic fall;
  // reset loads cs_n high and sclk low, the idle levels of the pins,
  // so no false edge or frame start follows reset

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 3'h1;
      s2_q <= 3'h1;
      sclk_prev_q <= 1'b0;
    end else begin
      s1_q <= {sclk, din, cs_n};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[2];
    end
  end

  assign cs_n_s = s2_q[0];
  assign din_s = s2_q[1];
  assign sclk_s = s2_q[2];
  // edges only count inside a frame; a deselected port ignores sclk
  assign rise = sclk_s && !sclk_prev_q && !cs_n_s;
  assign fall = !sclk_s && sclk_prev_q && !cs_n_s;

  // receive state
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_RX = 2'b01,
    SADC_CONV = 2'b10
  } sadc_state_t;

  // receive side: state, shift register and bit count
  sadc_state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] rx_cnt_q;
  logic byte_done_q; // one mclk pulse after the eighth bit
  // conversion side: decisions so far and the collected result
  logic [3:0] res_cnt_q;
  logic [11:0] res_q;
  logic strobe_pend_q; // byte asked for a conversion, waits for a fall
  logic fifo_in_ready;
  // decoded view of the byte now in the shift register
  sadc_pkg::sadc_cfg_t cfg_d;
  logic [2:0] sel;
  logic [1:0] pcode;

  // field extraction of the finished byte
  assign sel = {shift_q[sadc_pkg::SADC_BIT_SEL_HI],
                shift_q[sadc_pkg::SADC_BIT_SEL_MID],
                shift_q[sadc_pkg::SADC_BIT_SEL_LO]};
  assign pcode = {shift_q[sadc_pkg::SADC_BIT_PWR_HI],
                  shift_q[sadc_pkg::SADC_BIT_PWR_LO]};

  // decode control byte into channel, coding and mode
  always_comb begin
    cfg_d = '0;
    cfg_d.chan_pos = {sel[1], sel[0], sel[2]};
    cfg_d.chan_neg = 3'h0;
    cfg_d.neg_is_gnd = 1'b1;
    if (!shift_q[sadc_pkg::SADC_BIT_CONFIG]) begin
      cfg_d.neg_is_gnd = 1'b0;
      cfg_d.chan_pos = {sel[1], sel[0], sel[2]};
      cfg_d.chan_neg = {sel[1], sel[0], !sel[2]};
    end
    cfg_d.unipolar = shift_q[sadc_pkg::SADC_BIT_CODING];
    cfg_d.pmode = sadc_pkg::SADC_PM_TABLE[{pcode, 1'b0} +: 2];
  end

  // control byte reception and conversion sequencing
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= SADC_IDLE;
      shift_q <= 8'h00;
      rx_cnt_q <= 4'h0;
      byte_done_q <= 1'b0;
    end else begin
      byte_done_q <= 1'b0;
      if (cs_n_s) begin
        // frame ended, drop any partial byte
        if (state_q == SADC_RX) begin
          state_q <= SADC_IDLE;
        end
      end else if (rise) begin
        unique case (state_q)
          SADC_IDLE: begin
            if (din_s) begin
              state_q <= SADC_RX;
              shift_q <= 8'h01;
              rx_cnt_q <= 4'h1;
            end
          end
          SADC_RX: begin
            shift_q <= {shift_q[6:0], din_s};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == sadc_pkg::SADC_LAST_BIT - 4'h1) begin
              byte_done_q <= 1'b1;
              state_q <= SADC_CONV;
            end
          end
          SADC_CONV: begin
            // start bit accepted once restart point passed
            // the previous result keeps shifting out under the new byte
            if (din_s && res_cnt_q >= sadc_pkg::SADC_RESTART_BIT) begin
              state_q <= SADC_RX;
              shift_q <= 8'h01;
              rx_cnt_q <= 4'h1;
            end
          end
          default: begin
            state_q <= SADC_IDLE;
          end
        endcase
      end else if (state_q == SADC_CONV && !convert_q && !strobe_pend_q
                   && !byte_done_q) begin
        // nothing pending and no conversion running: back to idle
        state_q <= SADC_IDLE;
      end
    end
  end

  // track and hold control on falling edges
  // a frame cut while tracking leaves track high until a fall outside SADC_RX
  always_ff @(posedge mclk) begin
    if (rst) begin
      track_q <= 1'b0;
    end else if (fall) begin
      // track after fifth bit, hold after eighth
      if (state_q == SADC_RX && rx_cnt_q == sadc_pkg::SADC_TRACK_BIT) begin
        track_q <= 1'b1;
      end else if (state_q != SADC_RX) begin
        track_q <= 1'b0;
      end
    end
  end

  // latch configuration when the byte completes
  // cfg_q stays put through the conversion, the record copies it
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q <= '{pmode: sadc_pkg::SADC_PM_RESET, default: '0};
    end else if (byte_done_q) begin
      cfg_q <= cfg_d;
    end
  end

  // conversion, strobe and data out on falling edges, cleared at once on deselect
  always_ff @(posedge mclk) begin
    if (rst) begin
      convert_q <= 1'b0;
      strobe_pend_q <= 1'b0;
      conversion_strobe_o <= 1'b0;
      dout_o <= 1'b0;
      res_cnt_q <= 4'h0;
      res_q <= 12'h000;
    end else if (cs_n_s) begin
      // outputs released, conversion abandoned
      // a frame cut mid-conversion leaves no record behind
      conversion_strobe_o <= 1'b0;
      dout_o <= 1'b0;
      convert_q <= 1'b0;
      strobe_pend_q <= 1'b0;
    end else begin
      if (byte_done_q) begin
        // only start plus both power bits converts here
        strobe_pend_q <= (pcode == sadc_pkg::SADC_PM_EXT_CODE);
      end
      // every output update on a falling edge
      if (fall) begin
        conversion_strobe_o <= 1'b0;
        if (strobe_pend_q) begin
          strobe_pend_q <= 1'b0;
          conversion_strobe_o <= 1'b1;
          convert_q <= 1'b1;
          res_cnt_q <= 4'h0;
          dout_o <= 1'b0;
        end else if (convert_q) begin
          // coding set by analog core from cfg_q.unipolar
          dout_o <= cmp_bit;
          res_q <= {res_q[10:0], cmp_bit};
          res_cnt_q <= res_cnt_q + 4'h1;
          if (res_cnt_q == sadc_pkg::SADC_RES_LAST) begin
            convert_q <= 1'b0;
          end
        end else begin
          dout_o <= 1'b0;
        end
      end
    end
  end

  // record push when the last decision lands
  // a full fifo loses the record and sets the sticky drop flag instead
  logic push_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      push_q <= 1'b0;
      rec_dropped_q <= 1'b0;
    end else begin
      push_q <= fall && convert_q && !cs_n_s
                && res_cnt_q == sadc_pkg::SADC_RES_LAST;
      if (push_q && !fifo_in_ready) begin
        rec_dropped_q <= 1'b1;
      end
    end
  end

  // drive enables: active while chip select low
  // enables follow chip select one mclk after the synchroniser
  always_ff @(posedge mclk) begin
    if (rst) begin
      dout_oe <= 1'b0;
      conversion_strobe_oe <= 1'b0;
    end else begin
      dout_oe <= !cs_n_s;
      conversion_strobe_oe <= !cs_n_s;
    end
  end

  // fifo between the serial side and the record stream
  sadc_pkg::sadc_word_t fifo_out;
  logic fifo_valid;

  // pop only when the output stage is empty or being drained
  sadc_fifo #(
    .WIDTH(sadc_pkg::SADC_WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data({cfg_q, res_q}),
    .out_valid(fifo_valid),
    .out_ready(rec_ready && !(rec_valid && !rec_ready) || !rec_valid),
    .out_data(fifo_out)
  );

  // output register stage of the record stream
  // a stalled word stands unchanged until the sink takes it
  always_ff @(posedge mclk) begin
    if (rst) begin
      rec_valid <= 1'b0;
      rec_data <= '0;
    end else if (!rec_valid || rec_ready) begin
      rec_valid <= fifo_valid;
      if (fifo_valid) begin
        rec_data <= fifo_out;
      end
    end
  end

endmodule : sadc_ctrl

// >>> dv/sadc_ctrl_sva.sv
/* sadc_ctrl_sva: serial port timing checks on sadc_ctrl, plus pair decode and record stall checks.
   assumes: bound to sadc_ctrl; sclk phases last well over 6 mclk. */
`timescale 1ns/100ps
module sadc_ctrl_sva (
  // clock, reset, pins
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic conversion_strobe_o,
  input wire logic conversion_strobe_oe,
  // core and records
  input wire logic track_q,
  input wire logic convert_q,
  input sadc_pkg::sadc_cfg_t cfg_q,
  input wire logic rec_valid,
  input wire logic rec_ready,
  input sadc_pkg::sadc_word_t rec_data
);
  logic sclk_q; // raw sclk one mclk ago
  logic [3:0] age_q; // mclk since the last raw sclk fall
  logic [1:0] sf_q; // sclk falls seen while strobe is high
  // edge history, sync lag is tolerated through age_q
  always_ff @(posedge mclk) begin
    sclk_q <= sclk;
    if (rst) age_q <= 4'hf;
    else if (sclk_q && !sclk) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end
  // strobe length in sclk periods
  always_ff @(posedge mclk) begin
    if (rst || !conversion_strobe_o) sf_q <= 2'h0;
    else if (sclk_q && !sclk) sf_q <= sf_q + 2'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_oe_released: assert property (
    cs_n [*5] |-> !dout_oe && !conversion_strobe_oe)
    else $error("outputs driven while deselected");
  a_oe_driven: assert property (
    !cs_n [*5] |-> dout_oe && conversion_strobe_oe)
    else $error("outputs idle while selected");
  a_dout_on_fall: assert property (
    !cs_n && $changed(dout_o) |-> age_q <= 4'h6)
    else $error("data out moved away from a falling edge");
  a_strobe_on_fall: assert property (
    !cs_n && $changed(conversion_strobe_o) |-> age_q <= 4'h6)
    else $error("strobe moved away from a falling edge");
  a_strobe_period: assert property (
    $fell(conversion_strobe_o) && !cs_n |-> sf_q == 2'h1)
    else $error("strobe not one period long");
  a_strobe_ext: assert property (
    $rose(conversion_strobe_o) |-> cfg_q.pmode == sadc_pkg::SADC_PM_EXT_CLK)
    else $error("strobe outside external clock mode");
  a_hold_converts: assert property (
    $fell(track_q) && !cs_n && cfg_q.pmode == sadc_pkg::SADC_PM_EXT_CLK
      |-> ##[0:2] convert_q)
    else $error("hold without conversion start");
  a_diff_pair: assert property (
    $changed(cfg_q) && !cfg_q.neg_is_gnd
      |-> cfg_q.chan_neg == (cfg_q.chan_pos ^ 3'h1))
    else $error("differential pair wrong");
  a_rec_hold: assert property (
    rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
    else $error("record changed while stalled");
endmodule : sadc_ctrl_sva
bind sadc_ctrl sadc_ctrl_sva sadc_ctrl_sva_i (.mclk(mclk), .rst(rst),
  .cs_n(cs_n), .sclk(sclk), .dout_o(dout_o), .dout_oe(dout_oe),
  .conversion_strobe_o(conversion_strobe_o),
  .conversion_strobe_oe(conversion_strobe_oe), .track_q(track_q),
  .convert_q(convert_q), .cfg_q(cfg_q), .rec_valid(rec_valid),
  .rec_ready(rec_ready), .rec_data(rec_data));

// >>> dv/sadc_master.sv
/* sadc_master: serial master driving the converter port.
   assumes: called by the bench; mclk at 100 MHz. */
`timescale 1ns/100ps
module sadc_master #(
  parameter int HALF = 25
) (
  // clock
  input wire logic mclk,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  // rises seen in this frame
  output int nbits
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    nbits = 0;
  end
  // 2 MHz, frame far below the droop limit
  task automatic xfer(input int n, input logic [47:0] tx,
    output logic [47:0] rx);
    rx = '0;
    @(negedge mclk);
    cs_n = 1'b0;
    nbits = 0;
    for (int i = n - 1; i >= 0; i--) begin
      din = tx[i];
      repeat (HALF) @(negedge mclk);
      sclk = 1'b1;
      rx = {rx[46:0], dout};
      nbits++;
      repeat (HALF) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge mclk);
    cs_n = 1'b1;
    din = ~din;
  endtask : xfer
endmodule : sadc_master

// >>> dv/test_sadc_ctrl.sv
/* test_sadc_ctrl: self-checking bench for sadc_ctrl.
   assumes: sadc_master as serial partner; bench is the analog core. */
`timescale 1ns/100ps
module test_sadc_ctrl;
  logic mclk, rst, cs_n, sclk, din, cmp_bit, rec_ready, dout_o, dout_oe;
  logic stb, stb_oe, track_q, convert_q, rec_valid, rec_dropped_q;
  sadc_pkg::sadc_cfg_t cfg_q;
  sadc_pkg::sadc_word_t rec_data;
  int err_count, comparisons, cyc, nbits, conv_n, idx, stb_n, trk_at;
  int hold_at, nrec, n0;
  logic [11:0] last_res, prev_res, cur_pat;
  logic [47:0] rx;
  sadc_ctrl #(.DEPTH(4)) sadc_ctrl_i (.mclk(mclk), .rst(rst),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o),
    .dout_oe(dout_oe), .conversion_strobe_o(stb),
    .conversion_strobe_oe(stb_oe), .cmp_bit(cmp_bit), .track_q(track_q),
    .convert_q(convert_q), .cfg_q(cfg_q), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .rec_data(rec_data),
    .rec_dropped_q(rec_dropped_q));
  sadc_master sadc_master_i (.mclk(mclk), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout(dout_oe ? dout_o : 1'bz), .nbits(nbits));
  // decision pattern of conversion n
  function automatic logic [11:0] pat_f(input int n);
    return 12'h9c5 ^ (n[11:0] * 12'h0b3);
  endfunction : pat_f
  assign cur_pat = pat_f(conv_n);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // analog stand-in: next decision on each rise of a conversion
  always @(posedge sclk) begin
    if (convert_q) cmp_bit <= cur_pat[idx];
    idx <= convert_q ? idx - 1 : 11;
  end
  always @(posedge convert_q) conv_n++;
  always @(posedge track_q) trk_at = nbits;
  always @(negedge track_q) hold_at = nbits;
  always @(posedge stb) stb_n++;
  // record sink and run limit
  always @(posedge mclk) begin
    cyc++;
    if (rec_valid && rec_ready) begin
      nrec++;
      prev_res = last_res;
      last_res = rec_data.result;
    end
    if (cyc == 80000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // one 24-clock read after z leading zeros
  task automatic conv(input logic [7:0] ctl, input int z);
    sadc_master_i.xfer(24 + z, {24'h0, ctl, 16'h0}, rx);
  endtask : conv
  // every single-ended code, unipolar, also framing and track timing
  task automatic t_single();
    for (int s = 0; s < 8; s++) begin
      n0 = stb_n;
      conv({1'b1, s[2:0], 4'hf}, 0);
      check(16'(cfg_q.chan_pos), {13'h0, s[1], s[0], s[2]});
      check(16'({cfg_q.neg_is_gnd, cfg_q.unipolar}), 16'h3);
      check(rx[15:0], {1'b0, pat_f(conv_n), 3'h0});
      check(16'(last_res), 16'(pat_f(conv_n)));
      check(16'({trk_at[3:0], hold_at[3:0]}), 16'h58);
      check(16'(stb_n - n0), 16'h1);
    end
  endtask : t_single
  // every differential code, bipolar
  task automatic t_diff();
    for (int s = 0; s < 8; s++) begin
      conv({1'b1, s[2:0], 4'h3}, 0);
      check(16'(cfg_q.chan_pos), {13'h0, s[1:0], s[2]});
      check(16'(cfg_q.chan_neg), {13'h0, s[1:0], ~s[2]});
      check(16'({cfg_q.neg_is_gnd, cfg_q.unipolar}), 16'h0);
    end
  endtask : t_diff
  // other power codes decode, no strobe and no record
  task automatic t_power();
    for (int p = 0; p < 3; p++) begin
      n0 = stb_n + nrec;
      conv({6'h3f, p[1:0]}, 0);
      check(16'(cfg_q.pmode), 16'(p));
      check(16'(stb_n + nrec), 16'(n0));
    end
  endtask : t_power
  // leading zeros, then two conversions fifteen clocks apart
  task automatic t_stream();
    conv(8'hff, 5);
    check(rx[15:0], {1'b0, pat_f(conv_n), 3'h0});
    n0 = nrec;
    sadc_master_i.xfer(39, {9'h0, 8'h9f, 7'h0, 8'hdf, 16'h0}, rx);
    check(16'(nrec - n0), 16'h2);
    check(16'(prev_res), 16'(pat_f(conv_n - 1)));
    check(rx[15:0], {1'b0, pat_f(conv_n), 3'h0});
  endtask : t_stream
  // deselect in mid conversion
  task automatic t_abort();
    n0 = nrec;
    sadc_master_i.xfer(12, {36'h0, 8'hff, 4'h0}, rx);
    repeat (10) @(negedge mclk);
    check(16'({dout_oe, stb_oe, convert_q}), 16'h0);
    check(16'(nrec), 16'(n0));
  endtask : t_abort
  // fill the record fifo until it drops, then drain it
  task automatic t_fifo();
    rec_ready = 1'b0;
    n0 = conv_n;
    repeat (4) conv(8'hef, 0);
    check(16'(rec_dropped_q), 16'h0);
    repeat (2) conv(8'hef, 0);
    check(16'(rec_dropped_q), 16'h1);
    check(16'({rec_valid, rec_data.result}), {4'h1, pat_f(n0 + 1)});
    n0 = nrec;
    rec_ready = 1'b1;
    for (int i = 0; i < 40 && (rec_valid !== 1'b0 || i < 2); i++)
      @(negedge mclk);
    check(16'(rec_valid), 16'h0);
    check(16'(nrec - n0 >= 4), 16'h1);
  endtask : t_fifo
  initial begin
    rst = 1'b1;
    rec_ready = 1'b1;
    cmp_bit = 1'b0;
    idx = 11;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    check(16'(cfg_q.pmode), 16'h2);
    t_single();
    t_diff();
    t_power();
    t_stream();
    t_abort();
    t_fifo();
    give_verdict();
  end
endmodule : test_sadc_ctrl
